// [hdl/rmt_pkg.sv]
// Constants, register map and carriers for the receiver manual tuning control.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package rmt_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_TUNING = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// Tuning register fields
	localparam int TUN_CORNER_LSB = 0;
	localparam int TUN_MANUAL_BIT = 2;
	localparam int TUN_WIDEBW_BIT = 3;
	localparam int TUN_PARITY_BIT = 4;
	localparam int TUN_DELAY_BIT  = 5;
	localparam int TUN_FAST_BIT   = 6;
	localparam logic [7:0] TUN_RESET     = 8'h00;
	localparam logic [7:0] TUN_WRITE_MSK = 8'h7f;

	// Configuration register fields
	localparam int CFG_SEL_LSB   = 0;
	localparam int CFG_DRV_LSB   = 4;
	localparam int CFG_PHASE_LSB = 8;
	localparam int CFG_WAIT_LSB  = 16;

	// Status register fields
	localparam int STA_CORNER_LSB = 0;
	localparam int STA_DELAY_BIT  = 2;
	localparam int STA_PERR_BIT   = 3;

	// Selector code that routes the delayed secure output
	localparam logic [3:0] SEL_DELAYED = 4'hc;

	// Delay arithmetic, in delay-line steps
	localparam int DELAY_W        = 9;
	localparam int EXTRA_WAIT_STEP = 128;

	typedef enum logic [1:0]
	{
		RMT_CORNER_106 = 2'h0,
		RMT_CORNER_212 = 2'h1,
		RMT_CORNER_424 = 2'h2,
		RMT_CORNER_848 = 2'h3
	} rmt_corner_e;

	// Byte to transmit, and serial word with optional parity
	typedef struct packed
	{
		logic       valid;
		logic [7:0] data;
	} rmt_tx_byte_s;

	typedef struct packed
	{
		logic       valid;
		logic [8:0] bits;
		logic [3:0] count;
	} rmt_tx_word_s;

	// Received word: parity position in bit 8
	typedef struct packed
	{
		logic       valid;
		logic [8:0] bits;
	} rmt_rx_word_s;

	typedef struct packed
	{
		logic       valid;
		logic [8:0] data;
		logic [3:0] count;
		logic       parityErr;
	} rmt_rx_byte_s;

endpackage

// [hdl/rmt_tuning.sv]
// Receiver manual tuning control: register file on classic Wishbone, parity gating,
// programmable secure-out delay and filter corner selection.
// Assumes framing logic around it on sys_clk; secure input pin is asynchronous.
// Notes on behaviour
// [RULE_01] With parity off no parity bit is added on transmit and none is checked on receive.
// [RULE_02] With parity off the received parity-position bit is passed on as a ninth data bit.
// [RULE_03] With delay enabled and selector 1100b the secure output is delayed by bit phase and wait.
// [RULE_04] With delay disabled the secure output gets no programmable delay.
// [RULE_05] Firmware should enable the delay only with selector 1110b or 1111b; the code delays only with selector 1100b.
// [RULE_06] In card emulation the secure IC answers 128 carrier periods early when delay is on.
// [RULE_07] With manual corner off the corner field is ignored and the corner follows receive mode.
// [RULE_08] With manual corner on, field 00/01/10/11 picks 106/212/424/848 kHz.
// [RULE_09] Firmware should set fast filtering only for pauses shorter than 400 ns.
// [RULE_10] Extra wait and seven-bit bit phase together set the extra response delay.
// [RULE_11] The top tuning bit reads zero and ignores writes.
`timescale 1ns/1ps
`default_nettype none

module rmt_tuning #(
	parameter int DEPTH = 512
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output var  logic [31:0]          wb_dat_o,
	output var  logic                 wb_ack_o,
	// Framing side
	input  wire rmt_pkg::rmt_tx_byte_s txByte,
	output var  rmt_pkg::rmt_tx_word_s txWord,
	input  wire rmt_pkg::rmt_rx_word_s rxWord,
	output var  rmt_pkg::rmt_rx_byte_s rxByte,
	input  wire logic [1:0]           rxSpeed,
	// Analog controls
	output var  logic [1:0]           highpassCorner,
	output var  logic                 fastMillerFilter,
	output var  logic                 wideClockRecoveryBw,
	// Secure IC lines
	input  wire logic                 secureOutSource,
	output var  logic                 secure_out_pin,
	input  wire logic                 secure_in_pin,
	output var  logic                 secureInSync
);

	logic [7:0]                    tuning_q;
	logic [3:0]                    signal_out_selector_q;
	logic [1:0]                    driver_selector_q;
	logic [6:0]                    transmit_bit_phase_q;
	logic [1:0]                    transmit_extra_wait_q;
	logic                          parityErrSeen_q;
	logic                          wrStrobe;
	logic                          delayActive;
	logic [rmt_pkg::DELAY_W-1:0]   delayAmount;
	logic [DEPTH-2:0]              delayLine_q;
	logic [DEPTH-1:0]              delayTap;
	logic [1:0]                    inSync_q;
	logic                          rxParityBad;

	function automatic logic oddParity(input logic [7:0] d);
		oddParity = ~(^d);
	endfunction

	// Write lands at the ack edge, where the master completes the cycle
	assign wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	// Wishbone answer one cycle after the request, then drops
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
		begin
			unique case (wb_adr_i)
				rmt_pkg::ADDR_TUNING: wb_dat_o <= {24'h00_0000, tuning_q};
				rmt_pkg::ADDR_CONFIG: wb_dat_o <= {14'h0000, transmit_extra_wait_q, 1'b0,
					transmit_bit_phase_q, 2'h0, driver_selector_q, signal_out_selector_q};
				rmt_pkg::ADDR_STATUS: wb_dat_o <= {28'h000_0000, parityErrSeen_q, delayActive,
					highpassCorner};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tuning_q <= rmt_pkg::TUN_RESET;
		else if (wrStrobe && wb_adr_i == rmt_pkg::ADDR_TUNING && wb_sel_i[0])
			tuning_q <= wb_dat_i[7:0] & rmt_pkg::TUN_WRITE_MSK; // [RULE_11]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			signal_out_selector_q <= 4'h0;
			driver_selector_q     <= 2'h0;
			transmit_bit_phase_q  <= 7'h00;
			transmit_extra_wait_q <= 2'h0;
		end
		else if (wrStrobe && wb_adr_i == rmt_pkg::ADDR_CONFIG)
		begin
			if (wb_sel_i[0])
			begin
				signal_out_selector_q <= wb_dat_i[rmt_pkg::CFG_SEL_LSB +: 4];
				driver_selector_q     <= wb_dat_i[rmt_pkg::CFG_DRV_LSB +: 2];
			end
			if (wb_sel_i[1])
				transmit_bit_phase_q <= wb_dat_i[rmt_pkg::CFG_PHASE_LSB +: 7];
			if (wb_sel_i[2])
				transmit_extra_wait_q <= wb_dat_i[rmt_pkg::CFG_WAIT_LSB +: 2];
		end
	end

	// Sticky parity error; a new error beats a write-one clear
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			parityErrSeen_q <= 1'b0;
		else if (rxParityBad)
			parityErrSeen_q <= 1'b1;
		else if (wrStrobe && wb_adr_i == rmt_pkg::ADDR_STATUS && wb_sel_i[0]
			&& wb_dat_i[rmt_pkg::STA_PERR_BIT])
			parityErrSeen_q <= 1'b0;
	end

	// Transmit parity insertion
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			txWord <= '0;
		else
		begin
			txWord.valid <= txByte.valid;
			if (tuning_q[rmt_pkg::TUN_PARITY_BIT])
			begin
				txWord.bits  <= {1'b0, txByte.data}; // [RULE_01]
				txWord.count <= 4'h8;
			end
			else
			begin
				txWord.bits  <= {oddParity(txByte.data), txByte.data};
				txWord.count <= 4'h9;
			end
		end
	end

	// Receive parity check
	assign rxParityBad = rxWord.valid & ~tuning_q[rmt_pkg::TUN_PARITY_BIT]
		& (rxWord.bits[8] != oddParity(rxWord.bits[7:0])); // [RULE_01]

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rxByte <= '0;
		else
		begin
			rxByte.valid     <= rxWord.valid;
			rxByte.parityErr <= rxParityBad;
			if (tuning_q[rmt_pkg::TUN_PARITY_BIT])
			begin
				rxByte.data  <= rxWord.bits; // [RULE_02]
				rxByte.count <= 4'h9;
			end
			else
			begin
				rxByte.data  <= {1'b0, rxWord.bits[7:0]};
				rxByte.count <= 4'h8;
			end
		end
	end

	// Delay only on the dedicated selector code
	assign delayActive = tuning_q[rmt_pkg::TUN_DELAY_BIT]
		&& signal_out_selector_q == rmt_pkg::SEL_DELAYED; // [RULE_03]
	// Extra wait counts in whole bit-phase spans
	assign delayAmount = rmt_pkg::DELAY_W'(transmit_extra_wait_q * rmt_pkg::EXTRA_WAIT_STEP)
		+ rmt_pkg::DELAY_W'(transmit_bit_phase_q); // [RULE_10]

	// Shift register trades area for a glitch-free delay of up to DEPTH-1 steps
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			delayLine_q <= '0;
		else
			delayLine_q <= {delayLine_q[DEPTH-3:0], secureOutSource};
	end

	// Tap 0 is the live source, so the added delay equals the programmed amount
	assign delayTap = {delayLine_q, secureOutSource};

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			secure_out_pin <= 1'b0;
		else if (delayActive)
			secure_out_pin <= delayTap[delayAmount]; // [RULE_03]
		else
			secure_out_pin <= secureOutSource; // [RULE_04]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			inSync_q <= 2'h0;
		else
			inSync_q <= {inSync_q[0], secure_in_pin};
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			secureInSync <= 1'b0;
		else
			secureInSync <= inSync_q[1];
	end

	// Filter controls
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			highpassCorner      <= rmt_pkg::RMT_CORNER_106;
			fastMillerFilter    <= 1'b0;
			wideClockRecoveryBw <= 1'b0;
		end
		else
		begin
			if (tuning_q[rmt_pkg::TUN_MANUAL_BIT])
				highpassCorner <= tuning_q[rmt_pkg::TUN_CORNER_LSB +: 2]; // [RULE_08]
			else
				highpassCorner <= rxSpeed; // [RULE_07]
			fastMillerFilter    <= tuning_q[rmt_pkg::TUN_FAST_BIT];
			wideClockRecoveryBw <= tuning_q[rmt_pkg::TUN_WIDEBW_BIT];
		end
	end

endmodule

`default_nettype wire

// [tb/rmt_secure_ic.sv]
// Secure IC model: answers on its input line a fixed lag after the output.
// Assumes the sys_clk of the bench.
`timescale 1ns/1ps
`default_nettype none
module rmt_secure_ic #(
	parameter int LAG = 2
) (
	// Clock and lines
	input wire logic sys_clk,
	input wire logic secure_out_pin,
	output var logic secure_in_pin
);
	logic [LAG-1:0] lag_q = '0;
	always_ff @(posedge sys_clk)
	begin
		lag_q <= {lag_q[LAG-2:0], secure_out_pin};
	end
	assign secure_in_pin = lag_q[LAG-1];
endmodule
`default_nettype wire

// [tb/rmt_tuning_sva.sv]
// Port checks for rmt_tuning.
// Assumes one sys_clk domain, rst synchronous high.
`timescale 1ns/1ps
`default_nettype none
module rmt_tuning_sva (
	// Clock, reset, bus
	input wire logic                  sys_clk,
	input wire logic                  rst,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_ack_o,
	// Datapath
	input wire rmt_pkg::rmt_tx_byte_s txByte,
	input wire rmt_pkg::rmt_tx_word_s txWord,
	input wire rmt_pkg::rmt_rx_word_s rxWord,
	input wire rmt_pkg::rmt_rx_byte_s rxByte,
	input wire logic [1:0]            highpassCorner
);
	logic [8:0] rxPrev_q;
	always_ff @(posedge sys_clk)
	begin
		rxPrev_q <= rxWord.bits;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence taken_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
	ack_timing_a: assert property (taken_s |=> ack_s) else $error("ack late");
	reset_clear_a: assert property ($fell(rst) |-> highpassCorner == 2'h0 && !txWord.valid && !rxByte.valid)
		else $error("not cleared");
	tx_carry_a: assert property (txByte.valid |=> txWord.valid && txWord.bits[7:0] == $past(txByte.data))
		else $error("tx data");
	tx_idle_a: assert property (!txByte.valid |=> !txWord.valid) else $error("tx idle");
	tx_parity_a: assert property (txWord.valid |-> txWord.count == 4'h9 && txWord.bits[8] == ~^txWord.bits[7:0]
		|| txWord.count == 4'h8 && !txWord.bits[8]) else $error("tx parity");
	rx_raw_a: assert property (rxWord.valid |=> rxByte.valid && (rxByte.count == 4'h8
		|| rxByte.data == rxPrev_q && !rxByte.parityErr)) else $error("rx raw");
	rx_check_a: assert property (rxWord.valid |=> rxByte.count == 4'h9 || rxByte.data == {1'b0, rxPrev_q[7:0]}
		&& rxByte.parityErr == (rxPrev_q[8] == ^rxPrev_q[7:0])) else $error("rx check");
	rx_idle_a: assert property (!rxWord.valid |=> !rxByte.valid) else $error("rx idle");
endmodule
bind rmt_tuning rmt_tuning_sva u_sva (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .txByte, .txWord,
	.rxWord, .rxByte, .highpassCorner);
`default_nettype wire

// [tb/tb_top.sv]
// Bench for rmt_tuning: tuning table, then parity, delay and reset cases.
// Assumes the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                  sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]            wb_adr_i;
	logic [3:0]            wb_sel_i;
	logic [31:0]           wb_dat_i, wb_dat_o, rd;
	logic [1:0]            rxSpeed, highpassCorner;
	logic                  fastMillerFilter, wideClockRecoveryBw, secureOutSource;
	logic                  secure_out_pin, secure_in_pin, secureInSync;
	rmt_pkg::rmt_tx_byte_s txByte;
	rmt_pkg::rmt_tx_word_s txWord;
	rmt_pkg::rmt_rx_word_s rxWord;
	rmt_pkg::rmt_rx_byte_s rxByte;
	int                    mismatches, checked, n0, n1;
	// Row: tuning, speed, corner
	logic [11:0]           rows [6] = '{12'h073, 12'h04c, 12'h4d1, 12'h0e6, 12'h03a, 12'h005};
	rmt_tuning dut (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .txByte, .txWord, .rxWord, .rxByte, .rxSpeed, .highpassCorner,
		.fastMillerFilter, .wideClockRecoveryBw, .secureOutSource, .secure_out_pin, .secure_in_pin, .secureInSync);
	rmt_secure_ic ic (.sys_clk, .secure_out_pin, .secure_in_pin);
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic hang(input int n);
		if (n >= 600)
		begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	// Holds the request until ack is seen at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_sel_i <= 4'hf;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (i = 0; i < 600 && wb_ack_o !== 1'b1; i++)
			@(posedge sys_clk);
		hang(i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] t, input logic [8:0] r);
		@(posedge sys_clk);
		txByte <= '{1'b1, t};
		rxWord <= '{1'b1, r};
		@(posedge sys_clk);
		txByte.valid <= 1'b0;
		rxWord.valid <= 1'b0;
		#1;
	endtask
	// Edges from source rise to pin rise; drains the line after
	task automatic measure(output int n);
		int i;
		@(posedge sys_clk);
		secureOutSource <= 1'b1;
		for (n = 0; n < 600 && secure_out_pin !== 1'b1; n++)
			@(posedge sys_clk);
		hang(n);
		repeat (6) @(posedge sys_clk);
		chk(secureInSync, 1'b1);
		secureOutSource <= 1'b0;
		for (i = 0; i < 600 && secure_out_pin !== 1'b0; i++)
			@(posedge sys_clk);
		hang(i);
		// Old samples left in the line would fake an early edge on the next run
		repeat (520) @(posedge sys_clk);
	endtask
	initial
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, rxSpeed, secureOutSource} = '0;
		rst = 1'b1;
		wb_sel_i = 4'hf;
		txByte = '0;
		rxWord = '0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			@(posedge sys_clk);
			rxSpeed <= rows[i][3:2];
			wb(1'b1, rmt_pkg::ADDR_TUNING, 32'(rows[i][11:4]));
			wb(1'b0, rmt_pkg::ADDR_TUNING, 32'h0);
			chk(rd, 32'(rows[i][11:4]));
			chk(highpassCorner, rows[i][1:0]);
			chk(fastMillerFilter, rows[i][10]);
			chk(wideClockRecoveryBw, rows[i][7]);
		end
		wb(1'b1, rmt_pkg::ADDR_TUNING, 32'hff);
		wb(1'b0, rmt_pkg::ADDR_TUNING, 32'h0);
		chk(rd, 32'h7f);
		wb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, rmt_pkg::ADDR_TUNING, 32'h0);
		xfer(8'h03, 9'h107);
		chk(txWord, {1'b1, 9'h103, 4'h9});
		chk(rxByte, {1'b1, 9'h007, 4'h8, 1'b1});
		// Status: sticky error, no delay, automatic corner 01
		wb(1'b0, rmt_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h9);
		wb(1'b1, rmt_pkg::ADDR_STATUS, 32'h8);
		wb(1'b0, rmt_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, rmt_pkg::ADDR_TUNING, 32'h10);
		xfer(8'h07, 9'h107);
		chk(txWord, {1'b1, 9'h007, 4'h8});
		chk(rxByte, {1'b1, 9'h107, 4'h9, 1'b0});
		wb(1'b0, rmt_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, rmt_pkg::ADDR_CONFIG, 32'h0001050c);
		wb(1'b0, rmt_pkg::ADDR_CONFIG, 32'h0);
		chk(rd, 32'h0001050c);
		wb(1'b1, rmt_pkg::ADDR_TUNING, 32'h0);
		measure(n0);
		wb(1'b1, rmt_pkg::ADDR_TUNING, 32'h20);
		wb(1'b0, rmt_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h5);
		measure(n1);
		chk(n1 - n0, rmt_pkg::EXTRA_WAIT_STEP + 5);
		wb(1'b1, rmt_pkg::ADDR_CONFIG, 32'h0001050e);
		measure(n1);
		chk(n1, n0);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		wb(1'b0, rmt_pkg::ADDR_TUNING, 32'h0);
		chk(rd, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
